/* File: hw/ufa_pkg.sv */
`default_nettype none

package ufa_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_POWER_CONTROL_REG = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam int unsigned POWER_CONTROL_REG_SEL_BIT = 6;
   localparam int unsigned CTRL_TOP_BIT = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic IRQ_BIT_RST = 1'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ----------------------------------------
   // Interrupt status layout
   // ----------------------------------------
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_RX = 0;
   localparam int unsigned IRQ_FE = 1;
   localparam int unsigned IRQ_TX = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // ----------------------------------------
   // Bit timing: ticks of the 16x baud strobe, then data and frame bit counts
   // ----------------------------------------
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID = 4'h7;
   localparam logic [2:0] DATA_LAST = 3'h7;
   localparam logic [3:0] FRAME8_BITS = 4'hA;
   localparam logic [3:0] FRAME9_BITS = 4'hB;

   typedef enum logic [1:0] {
      MODE_SHIFT = 2'h0,
      MODE_UART8 = 2'h1,
      MODE_UART9_FIX = 2'h2,
      MODE_UART9_VAR = 2'h3
   } ufa_mode_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01,
      RX_START = 5'h02,
      RX_DATA = 5'h04,
      RX_NINTH = 5'h08,
      RX_STOP = 5'h10
   } ufa_rx_state_t;

   typedef struct packed {
      logic serial_mode_bit_lo;
      logic serial_mode_bit_hi;
      logic multiproc_enable;
      logic rx_enable;
      logic transmit_ninth_bit;
      logic received_ninth_bit;
      logic transmit_irq_flag;
      logic receive_irq_flag;
   } ufa_ctrl_t;

   typedef struct packed {
      logic [7:0] data;
      logic ninth;
      logic stop;
   } ufa_rx_frame_t;

endpackage

`default_nettype wire

/* File: hw/ufa_uart_top.sv */
// Chosen here: register access over AXI4-Lite and the register offsets.
`default_nettype none

module ufa_uart_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic baud_tick,
   input wire logic rxd,
   input wire logic [7:0] given_addr,
   input wire logic [7:0] bcast_addr,
   output logic txd,
   output logic irq
);

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic aw_have, w_have, wr_commit, rd_take;
   logic [7:0] aw_addr;
   logic [7:0] w_data;
   logic w_lane0;
   logic next_aw_have, next_w_have, next_rvalid;
   logic wr_ctrl, wr_power_control_reg, wr_data, wr_stat, wr_mask, wr_known;

   assign wr_commit = aw_have & w_have & ~bvalid;
   assign next_aw_have = aw_have ? ~wr_commit : (awvalid & awready);
   assign next_w_have = w_have ? ~wr_commit : (wvalid & wready);
   assign rd_take = arvalid & arready;
   assign next_rvalid = rd_take | (rvalid & ~rready);
   assign wr_ctrl = wr_commit & w_lane0 & (aw_addr == ufa_pkg::OFS_CTRL);
   assign wr_power_control_reg = wr_commit & w_lane0 & (aw_addr == ufa_pkg::OFS_POWER_CONTROL_REG);
   assign wr_data = wr_commit & w_lane0 & (aw_addr == ufa_pkg::OFS_DATA);
   assign wr_stat = wr_commit & w_lane0 & (aw_addr == ufa_pkg::OFS_STAT);
   assign wr_mask = wr_commit & w_lane0 & (aw_addr == ufa_pkg::OFS_MASK);
   assign wr_known = aw_addr inside {ufa_pkg::OFS_CTRL, ufa_pkg::OFS_POWER_CONTROL_REG, ufa_pkg::OFS_DATA,
                                     ufa_pkg::OFS_STAT, ufa_pkg::OFS_MASK};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_lane0 <= 1'b0;
      end else begin
         aw_have <= next_aw_have;
         w_have <= next_w_have;
         awready <= ~next_aw_have;
         wready <= ~next_w_have;
         if (awvalid && awready) begin
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_data <= wdata[7:0];
            w_lane0 <= wstrb[0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= ufa_pkg::RESP_OKAY;
      end else if (wr_commit) begin
         bvalid <= 1'b1;
         bresp <= wr_known ? ufa_pkg::RESP_OKAY : ufa_pkg::RESP_DECERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Serial control and power control
   // ----------------------------------------
   ufa_pkg::ufa_ctrl_t ctrl;
   logic frame_err_flag, bit7_function_select;
   logic [1:0] mode;
   logic rx_done, rx_accept, fe_event, tx_done;
   ufa_pkg::ufa_rx_frame_t rx_frame;
   logic [7:0] rx_buf;

   assign mode = {ctrl.serial_mode_bit_lo, ctrl.serial_mode_bit_hi};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bit7_function_select <= 1'b0;
      end else if (wr_power_control_reg) begin
         bit7_function_select <= w_data[ufa_pkg::POWER_CONTROL_REG_SEL_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= ufa_pkg::CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            // Bit 7 only reaches the mode bit while the selector is clear
            if (!bit7_function_select) begin
               ctrl.serial_mode_bit_lo <= w_data[ufa_pkg::CTRL_TOP_BIT];
            end
            ctrl[6:0] <= w_data[6:0];
         end
         // Hardware sets win over a same-cycle software clear
         if (rx_done && ctrl.rx_enable) begin
            ctrl.received_ninth_bit <= mode[1] ? rx_frame.ninth : rx_frame.stop;
         end
         if (rx_accept) begin
            ctrl.receive_irq_flag <= 1'b1;
         end
         if (tx_done) begin
            ctrl.transmit_irq_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_err_flag <= 1'b0;
      end else if (fe_event) begin
         frame_err_flag <= 1'b1;
      end else if (wr_ctrl && bit7_function_select && !w_data[ufa_pkg::CTRL_TOP_BIT]) begin
         frame_err_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // Receiver, 16x oversampled
   // ----------------------------------------
   ufa_pkg::ufa_rx_state_t rx_st;
   logic [3:0] rx_cnt;
   logic [2:0] rx_bit;
   logic addr_match, rx_mid, rxd_prev;

   assign rx_mid = baud_tick & (rx_cnt == ufa_pkg::OVS_LAST);
   // Given and broadcast must stay stable while recognition is enabled
   assign addr_match = (rx_frame.data == given_addr) | (rx_frame.data == bcast_addr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_st <= ufa_pkg::RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_frame <= '0;
         rx_done <= 1'b0;
         rxd_prev <= 1'b1;
      end else begin
         rx_done <= 1'b0;
         rxd_prev <= rxd;
         if (baud_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
         end
         if (!ctrl.rx_enable) begin
            rx_st <= ufa_pkg::RX_IDLE;
         end else begin
            unique case (rx_st)
               ufa_pkg::RX_IDLE: begin
                  rx_cnt <= '0;
                  // Falling edge only: a line left low by a bad stop bit is no new start
                  if (rxd_prev && !rxd) begin
                     rx_st <= ufa_pkg::RX_START;
                  end
               end
               ufa_pkg::RX_START: begin
                  // Recheck mid start bit so a glitch is not taken as a frame
                  if (baud_tick && rx_cnt == ufa_pkg::OVS_MID) begin
                     rx_cnt <= '0;
                     rx_bit <= '0;
                     rx_st <= rxd ? ufa_pkg::RX_IDLE : ufa_pkg::RX_DATA;
                  end
               end
               ufa_pkg::RX_DATA: begin
                  if (rx_mid) begin
                     rx_frame.data <= {rxd, rx_frame.data[7:1]};
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == ufa_pkg::DATA_LAST) begin
                        rx_st <= mode[1] ? ufa_pkg::RX_NINTH : ufa_pkg::RX_STOP;
                     end
                  end
               end
               ufa_pkg::RX_NINTH: begin
                  if (rx_mid) begin
                     rx_frame.ninth <= rxd;
                     rx_st <= ufa_pkg::RX_STOP;
                  end
               end
               ufa_pkg::RX_STOP: begin
                  if (rx_mid) begin
                     rx_frame.stop <= rxd;
                     rx_done <= 1'b1;
                     rx_st <= ufa_pkg::RX_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // Shift mode still samples a stop bit, but neither error nor recognition applies there
   assign fe_event = rx_done & ~rx_frame.stop & (mode != ufa_pkg::MODE_SHIFT);

   always_comb begin
      rx_accept = rx_done & ctrl.rx_enable;
      if (ctrl.multiproc_enable) begin
         unique case (mode)
            ufa_pkg::MODE_UART8: rx_accept = rx_accept & rx_frame.stop & addr_match;
            ufa_pkg::MODE_UART9_FIX, ufa_pkg::MODE_UART9_VAR:
               rx_accept = rx_accept & rx_frame.ninth & addr_match;
            ufa_pkg::MODE_SHIFT: rx_accept = rx_accept;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buf <= '0;
      end else if (rx_accept) begin
         rx_buf <= rx_frame.data;
      end
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   logic [10:0] tx_shift;
   logic [3:0] tx_left, tx_cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_shift <= '1;
         tx_left <= '0;
         tx_cnt <= '0;
         tx_done <= 1'b0;
         txd <= 1'b1;
      end else begin
         tx_done <= 1'b0;
         txd <= tx_shift[0];
         // A write while busy is dropped; software waits for the transmit flag
         if (wr_data && tx_left == '0) begin
            tx_cnt <= '0;
            if (mode[1]) begin
               tx_shift <= {1'b1, ctrl.transmit_ninth_bit, w_data, 1'b0};
               tx_left <= ufa_pkg::FRAME9_BITS;
            end else begin
               tx_shift <= {2'b11, w_data, 1'b0};
               tx_left <= ufa_pkg::FRAME8_BITS;
            end
         end else if (baud_tick && tx_left != '0) begin
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == ufa_pkg::OVS_LAST) begin
               tx_shift <= {1'b1, tx_shift[10:1]};
               tx_left <= tx_left - 4'h1;
               tx_done <= (tx_left == 4'h1);
            end
         end
      end
   end

   // ----------------------------------------
   // Interrupts and read path
   // ----------------------------------------
   logic [ufa_pkg::IRQ_W-1:0] irq_stat, irq_mask, irq_ev;
   logic [7:0] ctrl_view, rd_mux;
   logic rd_known;

   assign irq_ev = {tx_done, fe_event, rx_accept};

   generate
      for (genvar i = 0; i < ufa_pkg::IRQ_W; i++) begin : g_irq
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               irq_stat[i] <= ufa_pkg::IRQ_BIT_RST;
            end else if (irq_ev[i]) begin
               irq_stat[i] <= 1'b1;
            end else if (wr_stat && w_data[i]) begin
               irq_stat[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= ufa_pkg::IRQ_RST;
         irq <= 1'b0;
      end else begin
         if (wr_mask) begin
            irq_mask <= w_data[ufa_pkg::IRQ_W-1:0];
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

   assign ctrl_view = {bit7_function_select ? frame_err_flag : ctrl.serial_mode_bit_lo, ctrl[6:0]};

   always_comb begin
      rd_mux = '0;
      rd_known = 1'b1;
      unique case (araddr)
         ufa_pkg::OFS_CTRL: rd_mux = ctrl_view;
         ufa_pkg::OFS_POWER_CONTROL_REG: rd_mux[ufa_pkg::POWER_CONTROL_REG_SEL_BIT] = bit7_function_select;
         ufa_pkg::OFS_DATA: rd_mux = rx_buf;
         ufa_pkg::OFS_STAT: rd_mux[ufa_pkg::IRQ_W-1:0] = irq_stat;
         ufa_pkg::OFS_MASK: rd_mux[ufa_pkg::IRQ_W-1:0] = irq_mask;
         default: rd_known = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         arready <= 1'b0;
         rdata <= '0;
         rresp <= ufa_pkg::RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         arready <= ~next_rvalid;
         if (rd_take) begin
            rdata <= {24'h000000, rd_mux};
            rresp <= rd_known ? ufa_pkg::RESP_OKAY : ufa_pkg::RESP_DECERR;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_fe_on_bad_stop: assert property (rx_done && !rx_frame.stop
      && mode != ufa_pkg::MODE_SHIFT |=> frame_err_flag)
      else $error("framing error not flagged");
   a_bit7_view: assert property (ctrl_view[7] == (bit7_function_select ? frame_err_flag : mode[1]))
      else $error("bit 7 shows the wrong function");
   a_fe_sticky: assert property (frame_err_flag
      && !(wr_ctrl && bit7_function_select && !w_data[ufa_pkg::CTRL_TOP_BIT]) |=> frame_err_flag)
      else $error("framing error cleared by hardware");
   a_fe_good_frame: assert property (frame_err_flag && rx_done && rx_frame.stop |=> frame_err_flag)
      else $error("good frame cleared framing error");
   a_plain_receive: assert property (rx_done && ctrl.rx_enable
      && !ctrl.multiproc_enable |=> ctrl.receive_irq_flag)
      else $error("frame without recognition not flagged");
   a_nine_bit_filter: assert property (rx_done && ctrl.multiproc_enable && mode[1] && !wr_ctrl
      && !ctrl.receive_irq_flag && !(rx_frame.ninth && addr_match) |=> !ctrl.receive_irq_flag)
      else $error("unmatched nine-bit frame flagged");
   a_mode1_filter: assert property (rx_done && ctrl.multiproc_enable && mode == ufa_pkg::MODE_UART8
      && !wr_ctrl && !ctrl.receive_irq_flag && !(rx_frame.stop && addr_match) |=> !ctrl.receive_irq_flag)
      else $error("unmatched mode 1 frame flagged");
   a_no_rx_disabled: assert property (!ctrl.rx_enable |=> rx_st == ufa_pkg::RX_IDLE)
      else $error("receiver ran while disabled");
   a_tx_ninth: assert property (wr_data && tx_left == 4'h0 && mode[1]
      |=> tx_shift[9] == $past(ctrl.transmit_ninth_bit))
      else $error("ninth transmit bit wrong");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");

   c_addr_accept: cover property (rx_accept && ctrl.multiproc_enable && mode[1]);
   c_fe_set: cover property (fe_event ##1 frame_err_flag);
   c_tx_done: cover property (tx_done ##[1:3] irq);
   c_write_resp: cover property (wr_commit ##1 bvalid && bready);

endmodule // ufa_uart_top

`default_nettype wire

/* File: tb/ufa_node_model.sv */
`default_nettype none

// ----------------------------------------
// Far node on the serial line
// ----------------------------------------
module ufa_node_model (
   input wire logic aclk,
   input wire logic baud_tick,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ps;

   // Line idles high, as a pulled-up bus does between frames
   initial rxd = 1'b1;

   task automatic bit_out(input logic b);
      rxd <= b;
      repeat (16) @(posedge aclk iff baud_tick);
   endtask

   // Start bit, data LSB first, optional ninth bit, stop bit, then idle gap
   task automatic send(input logic [7:0] d, input logic nine, input logic has_nine, input logic stop);
      @(posedge aclk);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) begin
         bit_out(d[i]);
      end
      if (has_nine) begin
         bit_out(nine);
      end
      bit_out(stop);
      rxd <= 1'b1;
      repeat (32) @(posedge aclk iff baud_tick);
   endtask
endmodule // ufa_node_model

`default_nettype wire

/* File: tb/uart_frame_error_addr_match_tb_top.sv */
`default_nettype none

module uart_frame_error_addr_match_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic aclk = 1'b0, aresetn = 1'b0, baud_tick = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int err_count = 0;
   int cmp_count = 0;

   typedef struct packed {
      logic [1:0] mode;
      logic mpe;
      logic [7:0] d;
      logic nine;
      logic stop;
      logic acc;
      logic fe;
   } ufa_row_t;

   ufa_uart_top i_ufa_uart_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .baud_tick(baud_tick), .rxd(rxd),
      .given_addr(8'h5A), .bcast_addr(8'hFF), .txd(txd), .irq(irq));

   ufa_node_model i_ufa_node_model (.aclk(aclk), .baud_tick(baud_tick), .rxd(rxd));

   initial begin
      forever #2.5 aclk = ~aclk;
   end

   // 16x strobe every second clock keeps a frame near 350 cycles
   always_ff @(posedge aclk) begin
      baud_tick <= ~baud_tick;
   end

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic end_of_test();
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Address and data offered together; each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_ok, w_ok, b_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      b_ok = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_ok) begin
         @(posedge aclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            b_ok = 1'b1;
            bready <= 1'b0;
            chk_resp("bresp", er, bresp);
         end
      end
      // One edge between calls, so bready is never set twice in one step
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) begin
            arvalid <= 1'b0;
         end
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk_resp("rresp", ufa_pkg::RESP_OKAY, r);
      chk_val(name, e, d & m);
   endtask

   // Mode bits first with select clear, then select set and flags cleared
   task automatic setup(input logic [1:0] mode, input logic mpe, input logic ren);
      axi_wr(ufa_pkg::OFS_POWER_CONTROL_REG, 8'h00, ufa_pkg::RESP_OKAY);
      axi_wr(ufa_pkg::OFS_CTRL, {mode, mpe, ren, 4'h0}, ufa_pkg::RESP_OKAY);
      axi_wr(ufa_pkg::OFS_POWER_CONTROL_REG, 8'h40, ufa_pkg::RESP_OKAY);
      axi_wr(ufa_pkg::OFS_CTRL, {1'b0, mode[0], mpe, ren, 4'h0}, ufa_pkg::RESP_OKAY);
      axi_wr(ufa_pkg::OFS_STAT, 8'h07, ufa_pkg::RESP_OKAY);
   endtask

   // Samples txd in mid-bit: start, eight data, ninth, stop
   task automatic tx_grab(output logic [10:0] b);
      int n;
      n = 0;
      while (txd !== 1'b0 && n < 2000) begin
         @(posedge aclk);
         n++;
      end
      repeat (8) @(posedge aclk iff baud_tick);
      for (int i = 0; i < 11; i++) begin
         b[i] = txd;
         repeat (16) @(posedge aclk iff baud_tick);
      end
   endtask

   // ----------------------------------------
   // Ordinary receive cases: given 5A, broadcast FF
   // ----------------------------------------
   ufa_row_t rows [12] = '{
      '{2'h1, 1'b0, 8'h33, 1'b0, 1'b1, 1'b1, 1'b0},
      '{2'h1, 1'b0, 8'h33, 1'b0, 1'b0, 1'b1, 1'b1},
      '{2'h1, 1'b1, 8'h5A, 1'b0, 1'b1, 1'b1, 1'b0},
      '{2'h1, 1'b1, 8'h5A, 1'b0, 1'b0, 1'b0, 1'b1},
      '{2'h1, 1'b1, 8'h12, 1'b0, 1'b1, 1'b0, 1'b0},
      '{2'h2, 1'b1, 8'h5A, 1'b1, 1'b1, 1'b1, 1'b0},
      '{2'h2, 1'b1, 8'h5A, 1'b0, 1'b1, 1'b0, 1'b0},
      '{2'h3, 1'b1, 8'hFF, 1'b1, 1'b1, 1'b1, 1'b0},
      '{2'h3, 1'b1, 8'h12, 1'b1, 1'b1, 1'b0, 1'b0},
      '{2'h3, 1'b0, 8'h12, 1'b0, 1'b1, 1'b1, 1'b0},
      '{2'h0, 1'b0, 8'h3C, 1'b0, 1'b0, 1'b1, 1'b0},
      '{2'h2, 1'b0, 8'hC3, 1'b1, 1'b0, 1'b1, 1'b1}
   };

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [10:0] tb;
      logic rb8;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_val("txd_rst", 32'h1, {31'h0, txd});
      rd_chk("ctrl_rst", ufa_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0);
      rd_chk("stat_rst", ufa_pkg::OFS_STAT, 32'hFFFFFFFF, 32'h0);
      axi_wr(ufa_pkg::OFS_MASK, 8'h03, ufa_pkg::RESP_OKAY);
      foreach (rows[k]) begin
         setup(rows[k].mode, rows[k].mpe, 1'b1);
         // Multiproc enable stays clear in mode 0
         i_ufa_node_model.send(rows[k].d, rows[k].nine, rows[k].mode[1], rows[k].stop);
         repeat (8) @(posedge aclk);
         rd_chk("stat", ufa_pkg::OFS_STAT, 32'h3, {30'h0, rows[k].fe, rows[k].acc});
         rb8 = rows[k].mode[1] ? rows[k].nine : rows[k].stop;
         axi_rd(ufa_pkg::OFS_CTRL, d, r);
         chk_val("ctrl", {29'h0, rows[k].fe, rows[k].acc, rows[k].acc & rb8},
            {29'h0, d[7], d[0], d[2] & rows[k].acc});
         chk_val("irq", {31'h0, rows[k].acc | rows[k].fe}, {31'h0, irq});
         if (rows[k].acc) begin
            rd_chk("data", ufa_pkg::OFS_DATA, 32'hFFFFFFFF, {24'h0, rows[k].d});
         end
      end
      // Sticky error flag across a good frame, then cleared by software only
      setup(2'h1, 1'b0, 1'b1);
      i_ufa_node_model.send(8'h11, 1'b0, 1'b0, 1'b0);
      i_ufa_node_model.send(8'h22, 1'b0, 1'b0, 1'b1);
      rd_chk("fe_kept", ufa_pkg::OFS_CTRL, 32'h80, 32'h80);
      axi_wr(ufa_pkg::OFS_POWER_CONTROL_REG, 8'h00, ufa_pkg::RESP_OKAY);
      rd_chk("bit7_mode", ufa_pkg::OFS_CTRL, 32'hC0, 32'h40);
      axi_wr(ufa_pkg::OFS_POWER_CONTROL_REG, 8'h40, ufa_pkg::RESP_OKAY);
      axi_wr(ufa_pkg::OFS_CTRL, 8'hD0, ufa_pkg::RESP_OKAY);
      rd_chk("fe_w1", ufa_pkg::OFS_CTRL, 32'h80, 32'h80);
      axi_wr(ufa_pkg::OFS_CTRL, 8'h50, ufa_pkg::RESP_OKAY);
      rd_chk("fe_w0", ufa_pkg::OFS_CTRL, 32'h80, 32'h00);
      // Receiver disabled: frame ignored
      setup(2'h1, 1'b0, 1'b0);
      i_ufa_node_model.send(8'h44, 1'b0, 1'b0, 1'b1);
      rd_chk("stat_off", ufa_pkg::OFS_STAT, 32'h3, 32'h0);
      // Interrupt masked, unmasked, then cleared by a one
      setup(2'h1, 1'b0, 1'b1);
      axi_wr(ufa_pkg::OFS_MASK, 8'h00, ufa_pkg::RESP_OKAY);
      i_ufa_node_model.send(8'h55, 1'b0, 1'b0, 1'b1);
      chk_val("irq_mask", 32'h0, {31'h0, irq});
      axi_wr(ufa_pkg::OFS_MASK, 8'h01, ufa_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk_val("irq_on", 32'h1, {31'h0, irq});
      axi_wr(ufa_pkg::OFS_STAT, 8'h01, ufa_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk_val("irq_clr", 32'h0, {31'h0, irq});
      // Nine-bit transmit carries the ninth-bit field
      axi_wr(ufa_pkg::OFS_POWER_CONTROL_REG, 8'h00, ufa_pkg::RESP_OKAY);
      axi_wr(ufa_pkg::OFS_CTRL, 8'hC8, ufa_pkg::RESP_OKAY);
      axi_wr(ufa_pkg::OFS_MASK, 8'h04, ufa_pkg::RESP_OKAY);
      fork
         axi_wr(ufa_pkg::OFS_DATA, 8'hA5, ufa_pkg::RESP_OKAY);
         tx_grab(tb);
      join
      // Stop, ninth, data, start from the top down
      chk_val("tx_frame", {21'h0, 1'b1, 1'b1, 8'hA5, 1'b0}, {21'h0, tb});
      rd_chk("stat_tx", ufa_pkg::OFS_STAT, 32'h4, 32'h4);
      chk_val("irq_tx", 32'h1, {31'h0, irq});
      // Unmapped address on both channels
      axi_wr(8'h14, 8'hFF, ufa_pkg::RESP_DECERR);
      axi_rd(8'h14, d, r);
      chk_resp("rresp_unmapped", ufa_pkg::RESP_DECERR, r);
      chk_val("rdata_unmapped", 32'h0, d);
      end_of_test();
   end

   initial begin
      repeat (60000) @(posedge aclk);
      err_count++;
      end_of_test();
   end
endmodule // uart_frame_error_addr_match_tb_top

`default_nettype wire
